/* addr_dec_pkg.sv */
// package for the system address decoder: map constants, request types
// assumes one system bus clock shared by every master and target
package addr_dec_pkg;

    // ===========================================================
    // address map
    localparam logic [31:0] ROM_BASE    = 32'h0000_0000; // boot rom
    localparam logic [31:0] ROM_SIZE    = 32'h0001_0000; // 64 KB
    localparam logic [31:0] SRAM_BASE   = 32'h0800_0000; // sram window
    localparam logic [31:0] SRAM_SIZE   = 32'h0002_0000; // 128 KB
    localparam logic [31:0] FLASH_BASE  = 32'h1000_0000; // application flash
    localparam logic [31:0] FLASH_SIZE  = 32'h0004_0000; // 256 KB
    localparam logic [31:0] SFL_BASE    = 32'h1600_0000; // supervisory flash
    localparam logic [31:0] SFL_SIZE    = 32'h0000_8000; // 32 KB
    localparam logic [31:0] PRIV_BASE   = 32'hE000_0000; // core-private regs
    localparam logic [31:0] PRIV_LAST   = 32'hE00F_FFFF; // end of private range
    localparam logic [31:0] SYS_BASE    = 32'hE010_A000; // system registers
    localparam logic [2:0]  TOP_CODE    = 3'h0;          // a[31:29] code region
    localparam logic [2:0]  TOP_DATA    = 3'h1;          // empty data region
    localparam logic [2:0]  TOP_PERI    = 3'h2;          // peripheral region
    localparam int          BANK_LSB    = 15;            // 32 KB sram banks
    localparam int          BANKS       = 4;             // banks in 128 KB
    localparam logic [3:0]  SEC_CTX     = 4'h0;          // context allowed rom fetch

    // ===========================================================
    // masters, in service order
    localparam logic [1:0]  M_SEC       = 2'h0;          // secure_cpu
    localparam logic [1:0]  M_MAIN      = 2'h1;          // main_cpu
    localparam logic [1:0]  M_DBG       = 2'h2;          // debug_access_port

    // ===========================================================
    // types
    typedef enum logic [3:0] {
        T_NONE, T_ROM, T_SRAM, T_FLASH, T_SUPERVISORY_FLASH_SECTOR,
        T_PERI, T_XMEM, T_PRIV, T_SYSREG
    } target_e;

    typedef struct packed {
        logic        valid;  // request present, held until ready
        logic [31:0] addr;   // byte address
        logic        write;  // 1 write, 0 read
        logic        fetch;  // instruction fetch
        logic [3:0]  ctx;    // protection context
        logic [31:0] wdata;  // write data
    } req_s;

    typedef struct packed {
        logic        valid;  // one-cycle answer
        logic        err;    // bus error
        logic [31:0] rdata;  // read data
    } rsp_s;

    typedef struct packed {
        logic        valid;  // held until target answers
        target_e     tgt;    // selected target
        logic [31:0] addr;   // full address
        logic        write;  // direction
        logic [31:0] wdata;  // write data
        logic [1:0]  master; // issuing master
        logic [1:0]  bank;   // sram bank
    } tgt_req_s;

endpackage : addr_dec_pkg

/* addr_dec.sv */
// system address decoder: steers one access at a time from three masters
// assumes masters hold a request until ready, targets answer once per request
`timescale 1ns/1ps

module addr_dec
    import addr_dec_pkg::*;
#(
    parameter logic [31:0] SRAM_BYTES  = addr_dec_pkg::SRAM_SIZE,  // populated sram
    parameter logic [31:0] FLASH_BYTES = addr_dec_pkg::FLASH_SIZE  // populated flash
)(
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    input  wire addr_dec_pkg::req_s       sec_req,
    output      logic                     sec_ready,
    output      addr_dec_pkg::rsp_s       sec_rsp,
    input  wire addr_dec_pkg::req_s       main_req,
    output      logic                     main_ready,
    output      addr_dec_pkg::rsp_s       main_rsp,
    input  wire addr_dec_pkg::req_s       dbg_req,
    output      logic                     dbg_ready,
    output      addr_dec_pkg::rsp_s       dbg_rsp,
    output      addr_dec_pkg::tgt_req_s   tgt_req,
    input  wire addr_dec_pkg::rsp_s       tgt_rsp,
    input  wire logic [2:0]               sysfn_req,
    input  wire logic                     nmi_ack,
    output      logic                     secure_cpu_nmi,
    input  wire logic [3:0]               bank_on,
    input  wire logic [3:0]               bank_retain,
    input  wire logic                     deep_sleep,
    output      logic [3:0]               bank_pwr
);
    import addr_dec_pkg::*;

    // ===========================================================
    // state
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RESP} state_e;

    typedef struct packed {
        state_e      st;     // sequencer
        tgt_req_s    tr;     // latched target request
        logic        err;    // answer error
        logic [31:0] rdata;  // answer data
        logic        nmi;    // pending system function
        logic [3:0]  pwr;    // bank power enables
    } state_s;

    state_s r;    // registered state
    state_s nxt;  // next state

    typedef struct packed {
        target_e    tgt;  // target chosen
        logic       err;  // refuse with bus error
        logic [1:0] bank; // sram bank
    } dec_s;

    // ===========================================================
    // decode: map, populated sizes, fetch permission
    function automatic dec_s decode(input req_s q, input logic [1:0] m,
                                    input logic [3:0] on);
        dec_s d;
        logic [31:0] a;
        d = '{tgt: T_NONE, err: 1'b1, bank: 2'h0};
        a = q.addr;
        d.bank = a[BANK_LSB+1:BANK_LSB];
        // same table whatever the master, boot rom fetch aside
        if (a[31:29] == TOP_CODE)
        begin
            if (a < ROM_BASE + ROM_SIZE)
            begin
                d.tgt = T_ROM;
                // only the secure core in context 0 may run boot code
                d.err = q.fetch && !(m == M_SEC && q.ctx == SEC_CTX);
            end
            else if (a >= SRAM_BASE && a < SRAM_BASE + SRAM_BYTES)
            begin
                d.tgt = T_SRAM;
                d.err = !on[d.bank];  // unpowered bank refuses
            end
            else if (a >= FLASH_BASE && a < FLASH_BASE + FLASH_BYTES)
            begin
                d.tgt = T_FLASH;
                d.err = 1'b0;
            end
            else if (a >= SFL_BASE && a < SFL_BASE + SFL_SIZE)
            begin
                d.tgt = T_SUPERVISORY_FLASH_SECTOR;
                d.err = 1'b0;
            end
        end
        else if (a[31:29] == TOP_DATA)
        begin
            d.err = 1'b1;  // no memory here, never aliases sram
        end
        else if (a[31:29] == TOP_PERI)
        begin
            d.tgt = T_PERI;  // plain decode, no bit-band alias
            d.err = q.fetch;
        end
        else if (a[31:30] == 2'h1 || a[31:29] == 3'h4)
        begin
            d.tgt = T_XMEM;  // external window, fetch allowed
            d.err = 1'b0;
        end
        else if (a >= PRIV_BASE && a <= PRIV_LAST)
        begin
            d.tgt = T_PRIV;  // master field picks the issuing core
            d.err = q.fetch;
        end
        else if (a >= SYS_BASE)
        begin
            d.tgt = T_SYSREG;
            d.err = q.fetch;
        end
        // anything left (external device range, gaps) stays an error
        return d;
    endfunction : decode

    // ===========================================================
    // fixed order grant: secure core, main core, debug port
    logic       any_req;  // some master waits
    logic [1:0] gnt;      // master chosen this cycle
    req_s       sel;      // its request
    dec_s       dec;      // its decode
    logic       take;     // request accepted this edge

    always_comb
    begin
        any_req = sec_req.valid | main_req.valid | dbg_req.valid;
        if (sec_req.valid)
        begin
            gnt = M_SEC;
            sel = sec_req;
        end
        else if (main_req.valid)
        begin
            gnt = M_MAIN;
            sel = main_req;
        end
        else
        begin
            gnt = M_DBG;
            sel = dbg_req;
        end
        dec  = decode(sel, gnt, bank_on);
        take = (r.st == ST_IDLE) && any_req;
    end

    // handshakes are combinational off the registered state
    assign sec_ready  = take && gnt == M_SEC;
    assign main_ready = take && gnt == M_MAIN;
    assign dbg_ready  = take && gnt == M_DBG;

    // ===========================================================
    // sequencer and side state
    always_comb
    begin
        nxt = r;
        nxt.tr.valid = 1'b0;
        unique case (r.st)
            ST_IDLE:
            begin
                if (take)
                begin
                    nxt.tr = '{valid: 1'b0, tgt: dec.tgt, addr: sel.addr,
                               write: sel.write, wdata: sel.wdata,
                               master: gnt, bank: dec.bank};
                    nxt.rdata = 32'h0000_0000;
                    nxt.err   = dec.err;
                    if (dec.err)
                    begin
                        nxt.st = ST_RESP;  // answered locally
                    end
                    else
                    begin
                        nxt.tr.valid = 1'b1;
                        nxt.st       = ST_WAIT;
                    end
                end
            end
            ST_WAIT:
            begin
                if (tgt_rsp.valid)
                begin
                    nxt.err   = tgt_rsp.err;
                    nxt.rdata = tgt_rsp.rdata;
                    nxt.st    = ST_RESP;
                end
                else
                begin
                    nxt.tr.valid = 1'b1;  // hold until the target answers
                end
            end
            ST_RESP:
            begin
                nxt.st = ST_IDLE;  // exactly one answer per request
            end
        endcase
        // a new request wins over the acknowledge in the same cycle
        nxt.nmi = (r.nmi & ~nmi_ack) | (|sysfn_req);
        // retention set holds banks in deep sleep, else run set
        nxt.pwr = deep_sleep ? bank_retain : bank_on;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            r <= '0;
        end
        else
        begin
            r <= nxt;
        end
    end

    // ===========================================================
    // outputs
    rsp_s rsp_any;  // answer before steering to its master

    always_comb
    begin
        rsp_any = '{valid: r.st == ST_RESP, err: r.err, rdata: r.rdata};
        sec_rsp  = rsp_any;
        main_rsp = rsp_any;
        dbg_rsp  = rsp_any;
        sec_rsp.valid  = rsp_any.valid && r.tr.master == M_SEC;
        main_rsp.valid = rsp_any.valid && r.tr.master == M_MAIN;
        dbg_rsp.valid  = rsp_any.valid && r.tr.master == M_DBG;
    end

    assign tgt_req        = r.tr;
    assign secure_cpu_nmi = r.nmi;
    assign bank_pwr       = r.pwr;

    // ===========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic [31:0] ta;  // address taken
    assign ta = sel.addr;

    grant_order_a: assert property (
        (r.st == ST_IDLE && sec_req.valid) |-> sec_ready && !main_ready && !dbg_ready)
        else $error("secure core not served first");

    main_before_dbg_a: assert property (
        dbg_ready |-> !sec_req.valid && !main_req.valid)
        else $error("debug port served ahead of a core");

    unused_err_a: assert property (
        (take && ta[31:30] == 2'h2 && ta[29]) || (take && ta[31:29] == 3'h6)
        |=> rsp_any.valid && rsp_any.err && !tgt_req.valid)
        else $error("unused range not refused");

    rom_fetch_a: assert property (
        main_ready && main_req.fetch && ta < ROM_SIZE |=> main_rsp.valid && main_rsp.err)
        else $error("main core fetched boot rom");

    peri_fetch_a: assert property (
        take && sel.fetch && ta[31:29] == TOP_PERI |=> rsp_any.valid && rsp_any.err)
        else $error("fetch from peripherals allowed");

    data_empty_a: assert property (
        take && ta[31:29] == TOP_DATA |=> rsp_any.err ##1 r.st == ST_IDLE)
        else $error("data region reached a target");

    priv_route_a: assert property (
        take && !sel.fetch && ta >= PRIV_BASE && ta <= PRIV_LAST
        |=> tgt_req.valid && tgt_req.tgt == T_PRIV && tgt_req.master == $past(gnt))
        else $error("private access misrouted");

    sram_route_a: assert property (
        take && ta >= SRAM_BASE && ta < SRAM_BASE + SRAM_BYTES && bank_on == 4'hF
        |=> tgt_req.valid && tgt_req.tgt == T_SRAM && tgt_req.bank == $past(ta[16:15]))
        else $error("sram access misrouted");

    tgt_answer_a: assert property (
        tgt_req.valid && tgt_rsp.valid |=> rsp_any.valid && !tgt_req.valid ##1 !rsp_any.valid)
        else $error("target answer not returned once");

    nmi_raise_a: assert property (
        |sysfn_req |=> secure_cpu_nmi)
        else $error("system function did not raise nmi");

    bank_pwr_a: assert property (
        deep_sleep |=> bank_pwr == $past(bank_retain))
        else $error("retention set not applied");

    fetch_refuse_a: assert property (
        take && sel.fetch && ta >= PRIV_BASE
        |=> rsp_any.valid && rsp_any.err && !tgt_req.valid)
        else $error("fetch from private or system range allowed");

    xmem_fetch_a: assert property (
        take && (ta[31:29] == 3'h3 || ta[31:29] == 3'h4)
        |=> tgt_req.valid && tgt_req.tgt == T_XMEM)
        else $error("external window not routed");

    one_owner_a: assert property (
        $onehot0({sec_ready, main_ready, dbg_ready})
        && $onehot0({sec_rsp.valid, main_rsp.valid, dbg_rsp.valid}))
        else $error("more than one master served at once");

    busy_refuse_a: assert property (
        r.st != ST_IDLE |-> !sec_ready && !main_ready && !dbg_ready)
        else $error("request taken while busy");

    nmi_hold_a: assert property (
        secure_cpu_nmi && !nmi_ack |=> secure_cpu_nmi)
        else $error("pending nmi dropped without acknowledge");

    rom_ctx_a: assert property (
        sec_ready && sec_req.fetch && ta < ROM_SIZE && sec_req.ctx != SEC_CTX
        |=> sec_rsp.valid && sec_rsp.err)
        else $error("boot rom fetched outside context 0");

    tgt_hold_a: assert property (
        tgt_req.valid && !tgt_rsp.valid
        |=> tgt_req.valid && $stable(tgt_req.addr))
        else $error("target request changed before its answer");

    flash_route_a: assert property (
        take && ta >= FLASH_BASE && ta < FLASH_BASE + FLASH_BYTES
        |=> tgt_req.valid && tgt_req.tgt == T_FLASH)
        else $error("flash access misrouted");

    sram_read_c: cover property (take && dec.tgt == T_SRAM ##[1:20] rsp_any.valid);
    err_rsp_c:   cover property (take && dec.err ##1 rsp_any.err);
    contend_c:   cover property (sec_req.valid && main_req.valid && dbg_req.valid);
    nmi_c:       cover property (|sysfn_req ##1 secure_cpu_nmi ##[1:10] nmi_ack);

endmodule : addr_dec

/* tgt_model.sv */
// target model: stands for every memory and register target behind the decoder
// assumes tgt_req from the decoder holds steady while its valid is high
`timescale 1ns/1ps

module tgt_model
    import addr_dec_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    input  wire addr_dec_pkg::tgt_req_s tgt_req,
    input  wire logic                   slow,
    output      addr_dec_pkg::rsp_s     tgt_rsp
);
    // ===========================================================
    // answer sequencer
    int   cnt;  // cycles waited on the current access
    logic done; // answer already given for this access
    // outside an answer the data lines carry junk, never the last word
    // rom refuses writes with a bus error so a target error is passed back
    always @(posedge core_clk)
    begin
        if (sys_rst || tgt_req.valid !== 1'b1)
        begin
            tgt_rsp <= '{1'b0, 1'b0, $urandom};
            cnt     <= 0;
            done    <= 1'b0;
        end
        else if (!done && cnt >= (slow ? 4 : 0))
        begin
            // read data is the inverted address so a misrouted word shows
            tgt_rsp <= '{1'b1, tgt_req.write && tgt_req.tgt == T_ROM, ~tgt_req.addr};
            done    <= 1'b1;
        end
        else
        begin
            tgt_rsp <= '{1'b0, 1'b0, $urandom};
            cnt     <= cnt + 1;
        end
    end
endmodule : tgt_model

/* system_address_decoder_bench.sv */
// bench for the address decoder: three masters, target model, reference map
// assumes the decoder and target model of this folder, 100 MHz core_clk
`timescale 1ns/1ps

module system_address_decoder_bench;
    import addr_dec_pkg::*;
    // ===========================================================
    // signals
    logic     core_clk = 0;    // system clock
    logic     sys_rst  = 1;    // synchronous reset
    req_s     rq [3];          // requests of sec, main, dbg
    logic [2:0] rdy;           // takes
    rsp_s     rs [3];          // answers
    tgt_req_s tq;              // routed request
    rsp_s     tr;              // target answer
    logic [2:0] sysfn_req = 0; // system function requests
    logic     nmi_ack = 0;     // secure core acknowledge
    logic     nmi;             // pending system function
    logic [3:0] bank_on = 4'hF, bank_retain = 0, bank_pwr;
    logic     deep_sleep = 0;  // retention select
    logic     slow = 0;        // slow target answers
    int       err_count = 0, num_checks = 0, nexp [3], npls [3];
    logic [31:0] addrs [19] = '{32'h0, 32'hFFFC, 32'h1_0000, 32'h0800_0000, 32'h0801_FFFC,
        32'h0802_0000, 32'h1003_FFFC, 32'h1004_0000, 32'h1600_7FFC, 32'h1600_8000,
        32'h2000_0000, 32'h4000_1000, 32'h6000_0000, 32'h9FFF_FFFC, 32'hA000_0000,
        32'hE000_0000, 32'hE010_0000, 32'hE010_A000, 32'hFFFF_FFFC};
    time      tend [3];        // completion time per master

    initial forever #5 core_clk = ~core_clk;
    initial foreach (rq[i]) rq[i] = '0;

    // ===========================================================
    // design and far side
    addr_dec #(.SRAM_BYTES(SRAM_SIZE), .FLASH_BYTES(FLASH_SIZE)) addr_dec_i (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .sec_req(rq[0]), .sec_ready(rdy[0]), .sec_rsp(rs[0]),
        .main_req(rq[1]), .main_ready(rdy[1]), .main_rsp(rs[1]),
        .dbg_req(rq[2]), .dbg_ready(rdy[2]), .dbg_rsp(rs[2]),
        .tgt_req(tq), .tgt_rsp(tr), .sysfn_req(sysfn_req), .nmi_ack(nmi_ack),
        .secure_cpu_nmi(nmi), .bank_on(bank_on), .bank_retain(bank_retain),
        .deep_sleep(deep_sleep), .bank_pwr(bank_pwr));
    tgt_model tgt_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .tgt_req(tq),
        .slow(slow), .tgt_rsp(tr));

    // answer pulses counted on the settled edge so each shows once
    always @(negedge core_clk)
        for (int i = 0; i < 3; i++)
            if (rs[i].valid === 1'b1) npls[i]++;

    // ===========================================================
    // reference map: 0 = bus error, else the target code
    function automatic int exp_t(logic [31:0] a, bit f, int m, logic [3:0] c);
        if (a < ROM_BASE + ROM_SIZE) return (f && !(m == 0 && c == SEC_CTX)) ? 0 : 1;
        if (a >= SRAM_BASE && a < SRAM_BASE + SRAM_SIZE) return bank_on[a[16:15]] ? 2 : 0;
        if (a >= FLASH_BASE && a < FLASH_BASE + FLASH_SIZE) return 3;
        if (a >= SFL_BASE && a < SFL_BASE + SFL_SIZE) return 4;
        if (a >= 32'h4000_0000 && a < 32'h6000_0000) return f ? 0 : 5;
        if (a >= 32'h6000_0000 && a < 32'hA000_0000) return 6;
        if (a >= PRIV_BASE && a <= PRIV_LAST) return f ? 0 : 7;
        if (a >= SYS_BASE) return f ? 0 : 8;
        return 0; // code gaps, empty data region, unused window
    endfunction : exp_t

    // ===========================================================
    // checks and closing
    task automatic chk_w(logic [31:0] g, logic [31:0] e, string s);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask : chk_w

    task automatic results;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic hang(string s);
        err_count++;
        $display("mismatch %0t %s timed out", $time, s);
        results();
    endtask : hang

    // one access: hold until taken, then wait for its single answer
    task automatic acc(int m, logic [31:0] a, bit f, bit w, logic [3:0] c);
        int e;
        int n;
        target_e sn;
        logic [1:0] sm;
        tgt_req_s st;
        logic [31:0] wd;
        e = exp_t(a, f, m, c);
        sn = T_NONE;
        sm = 2'h3;
        st = '0;
        wd = $urandom;
        n = 0;
        @(posedge core_clk);
        #1;
        rq[m] = '{1'b1, a, w, f, c, wd};
        nexp[m]++;
        @(negedge core_clk);
        while (rdy[m] !== 1'b1)
        begin
            if (++n > 60) hang("take");
            @(negedge core_clk);
        end
        @(posedge core_clk);
        #1;
        rq[m] = '{1'b0, ~a, 1'b0, 1'b0, 4'h0, $urandom};
        n = 0;
        while (rs[m].valid !== 1'b1)
        begin
            if (tq.valid === 1'b1)
            begin
                sn = tq.tgt;
                sm = tq.master;
                st = tq;
            end
            if (++n > 60) hang("answer");
            @(posedge core_clk);
            #1;
        end
        tend[m] = $time;
        chk_w(32'(rs[m].err), 32'(e == 0 || (e == 1 && w)), "err");
        chk_w(32'(sn), 32'(e), "target");
        if (e != 0) chk_w(32'(sm), 32'(m), "owner");
        if (e != 0) chk_w(st.addr, a, "addr");
        if (e != 0) chk_w(32'(st.write), 32'(w), "dir");
        if (e != 0 && w) chk_w(st.wdata, wd, "wdata");
        if (e == 2) chk_w(32'(st.bank), 32'(a[16:15]), "bank");
        if (!w) chk_w(rs[m].rdata, e == 0 ? 32'h0 : ~a, "rdata");
    endtask : acc

    // ===========================================================
    // main sequence
    initial
    begin
        void'($urandom(48301));
        repeat (12) @(posedge core_clk);
        #1;
        sys_rst = 0;
        // whole map from every master, read, write and fetch
        foreach (addrs[k])
            for (int m = 0; m < 3; m++)
                for (int f = 0; f < 2; f++)
                begin
                    slow = $urandom_range(0, 1);
                    bank_on = 4'($urandom) | 4'h9;
                    acc(m, addrs[k], f[0], $urandom_range(0, 1),
                        $urandom_range(0, 1) ? 4'h0 : 4'h3);
                end
        // sram banks: per-bank power and retention select
        for (int b = 0; b < 4; b++)
        begin
            bank_on = 4'($urandom);
            acc(1, SRAM_BASE + (b << BANK_LSB) + 32'h40, 1'b0, 1'b0, 4'h2);
            bank_retain = 4'($urandom);
            deep_sleep = b[0];
            repeat (2) @(posedge core_clk);
            #1;
            chk_w(32'(bank_pwr), 32'(b[0] ? bank_retain : bank_on), "bank");
        end
        deep_sleep = 0;
        bank_on = 4'hF;
        // simultaneous requests finish in fixed order, one answer each
        for (int m = 1; m < 3; m++)
        begin
            fork
                acc(m - 1, 32'h1000_0100, 1'b0, 1'b0, 4'h0);
                acc(m, 32'h4000_0200, 1'b0, 1'b0, 4'h1);
            join
            chk_w(32'(tend[m - 1] < tend[m]), 32'h1, "order");
        end
        // system function request from each master raises the nmi
        for (int i = 0; i < 3; i++)
        begin
            sysfn_req = 3'(1 << i);
            @(posedge core_clk);
            #1;
            chk_w(32'(nmi), 32'h1, "nmi set");
            nmi_ack = 1'b1;
            sysfn_req = 3'(i == 1 ? 2 : 0);
            @(posedge core_clk);
            #1;
            sysfn_req = 3'h0;
            chk_w(32'(nmi), 32'(i == 1), "nmi ack");
            @(posedge core_clk);
            #1;
            nmi_ack = 1'b0;
            chk_w(32'(nmi), 32'h0, "nmi clear");
        end
        // mid-run reset drops a pending nmi and bank power, then the map works again
        sysfn_req = 3'h4;
        @(posedge core_clk);
        #1;
        sysfn_req = 3'h0;
        sys_rst = 1;
        repeat (2) @(posedge core_clk);
        #1;
        chk_w(32'({nmi, bank_pwr, tq.valid, rs[0].valid}), 32'h0, "reset");
        sys_rst = 0;
        acc(0, 32'h0000_0100, 1'b1, 1'b0, 4'h0);
        repeat (3) @(posedge core_clk);
        for (int m = 0; m < 3; m++) chk_w(npls[m], nexp[m], "count");
        results();
    end
endmodule : system_address_decoder_bench
